//--- src/vrt_pkg.sv
// Purpose: Constants and carriers for the regulator telemetry/config bank
// Assumes: Registers are 8 bits wide, addressed by an 8-bit index
// Notes: Two address domains, the main one and the input-power one
//
// Behaviour
// - Output current reads 8-bit, platform maximum current reads as FFh.
// - Output voltage reading LSB is 8 mV fine step, 15.625 mV coarse.
// - Temperature reads whole degrees C; 100 C is 64h; zero means unsupported.
// - Output power is voltage reading times current reading, upper 8 bits of the product kept.
// - Input voltage reading minus two, divided by seven, gives volts.
// - Reading the second status register copies it into the snapshot.
// - Platform maximum current is caught from its strap once, then read-only.
// - Maximum temperature register starts at 64h, 100 degrees C.
// - Fast slew rate reads in millivolts per microsecond.
// - Slow slew rate is fast rate over 16, 8, 4 or 2; over two after reset, unknown codes over four.
// - Writable divider selector picks 2, 4, 8 or 16; resets to 02h.
// - Output targets strapped boot voltage until a set-voltage command arrives after the straps are caught.
// - Deepest power-state exit latency reads 7Bh microseconds.
// - Light-load power-state exit latency reads 55h microseconds.
// - Current limit level is writable and resets to zero.
// - Input-power reading exists only in domain 0Dh and resets to zero.
// - Status bits: 2 current limit, 1 frame fault, 0 parity fault.

package vrt_pkg;

	// Register indexes
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h11;
	localparam logic [7:0] ADDR_IOUT = 8'h15;
	localparam logic [7:0] ADDR_VOUT = 8'h16;
	localparam logic [7:0] ADDR_TEMP = 8'h17;
	localparam logic [7:0] ADDR_POUT = 8'h18;
	localparam logic [7:0] ADDR_VIN = 8'h1a;
	localparam logic [7:0] ADDR_PIN = 8'h1b;
	localparam logic [7:0] ADDR_SNAP = 8'h1c;
	localparam logic [7:0] ADDR_CLIM = 8'h1f;
	localparam logic [7:0] ADDR_MAX_CURRENT_STRAP_PIN = 8'h21;
	localparam logic [7:0] ADDR_TMAX = 8'h22;
	localparam logic [7:0] ADDR_FAST_SLEW_RATE = 8'h24;
	localparam logic [7:0] ADDR_SLOW_SLEW_RATE = 8'h25;
	localparam logic [7:0] ADDR_BOOT = 8'h26;
	localparam logic [7:0] ADDR_SR_SEL = 8'h2a;
	localparam logic [7:0] ADDR_DEEP_LAT = 8'h2b;
	localparam logic [7:0] ADDR_LIGHT_LAT = 8'h2c;

	// Values after reset, fixed read values and full scale
	localparam logic [7:0] RST_TELEM = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TMAX = 8'h64;
	localparam logic [7:0] RST_SR_SEL = 8'h02;
	localparam logic [7:0] VAL_DEEP_LAT = 8'h7b;
	localparam logic [7:0] VAL_LIGHT_LAT = 8'h55;
	localparam logic [7:0] FULL_SCALE = 8'hff;

	// Divider selector codes
	localparam logic [7:0] SEL_DIV2 = 8'h02;
	localparam logic [7:0] SEL_DIV4 = 8'h04;
	localparam logic [7:0] SEL_DIV8 = 8'h08;
	localparam logic [7:0] SEL_DIV16 = 8'h10;

	// Scaling: fine LSB 8 mV as a shift, coarse LSB 125/8 mV
	localparam int FINE_SHIFT = 3;
	localparam logic [15:0] COARSE_NUM = 16'h0008;
	localparam logic [15:0] COARSE_DEN = 16'h007d;
	localparam logic [23:0] VIN_PER_V = 24'h000007;
	localparam logic [23:0] MV_PER_V = 24'h0003e8;
	localparam logic [23:0] VIN_OFFSET = 24'h000002;

	// Status bit positions
	localparam int STAT_CLIM_BIT = 2;
	localparam int STAT_FRAME_BIT = 1;
	localparam int STAT_PARITY_BIT = 0;

	// Cycles after reset release before the straps are caught
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Access request from the link side
	typedef struct packed {
		logic [7:0] addr;
		logic psys;
		logic wr;
		logic [7:0] wdata;
	} vrt_req_s;

	// Answer to the link side
	typedef struct packed {
		logic [7:0] rdata;
		logic ok;
	} vrt_rsp_s;

	// Live measurements from the converters, system clock domain
	typedef struct packed {
		logic [7:0] current_a;
		logic [11:0] vout_mv;
		logic [7:0] temp_c;
		logic temp_valid;
		logic [15:0] vin_mv;
		logic [7:0] pin;
	} vrt_meas_s;

endpackage : vrt_pkg

//--- src/vrt_regs.sv
// Purpose: Telemetry and configuration register bank of the regulator
// Assumes: Bus framing lives in the link-clock protocol engine outside
// Notes: One access in flight at a time, crossed by toggle handshake
`timescale 1ns/1ps

module vrt_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_link,
	input wire logic i_link_req_valid,
	input wire vrt_pkg::vrt_req_s i_link_req,
	output logic o_link_busy,
	output logic o_link_done,
	output vrt_pkg::vrt_rsp_s o_link_rsp,
	input wire vrt_pkg::vrt_meas_s i_meas,
	input wire logic i_fine_step,
	input wire logic [2:0] i_status_two,
	input wire logic [7:0] i_max_current_strap_pin,
	input wire logic [7:0] i_fast_slew_strap,
	input wire logic [7:0] i_boot_strap,
	input wire logic i_set_voltage_valid,
	input wire logic [7:0] i_set_voltage_code,
	output logic o_strap_done,
	output logic [7:0] o_current_limit_level,
	output logic [7:0] o_slow_slew_rate,
	output logic [7:0] o_target_voltage_code
);
	import vrt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Link clock domain
	logic req_tgl;
	logic ack_seen;
	logic ack_s;
	vrt_req_s req_hold;
	logic ack_tgl;
	vrt_rsp_s rsp_hold;

	// Busy while our toggle has not come back
	assign o_link_busy = req_tgl ^ ack_seen;

	// Take a request only when idle; a request while busy is dropped
	always_ff @(posedge i_clk_link or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_tgl <= 1'b0;
			req_hold <= '0;
		end else if (i_link_req_valid && !o_link_busy) begin
			req_tgl <= ~req_tgl;
			req_hold <= i_link_req;
		end
	end

	vrt_sync #(
		.W(1)
	) u_ack_sync (
		.i_clk(i_clk_link),
		.i_rst_n(i_rst_n),
		.i_d(ack_tgl),
		.o_q(ack_s)
	);

	// Answer is stable in the system domain once its toggle is seen
	always_ff @(posedge i_clk_link or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_seen <= 1'b0;
			o_link_done <= 1'b0;
			o_link_rsp <= '0;
		end else begin
			o_link_done <= ack_s ^ ack_seen;
			if (ack_s ^ ack_seen) begin
				ack_seen <= ack_s;
				o_link_rsp <= rsp_hold;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System domain: request detection
	logic req_s;
	logic req_seen;
	logic access;

	vrt_sync #(
		.W(1)
	) u_req_sync (
		.i_clk(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_d(req_tgl),
		.o_q(req_s)
	);

	// req_hold is frozen while the toggle is in flight, so it is safe here
	assign access = req_s ^ req_seen;

	////////////////////////////////////////////////////////////////////////
	// Strap capture
	logic [23:0] strap_s;
	logic [1:0] strap_cnt;
	logic [7:0] platform_max_current;
	logic [7:0] fast_slew_rate;
	logic [7:0] boot_voltage;

	vrt_sync #(
		.W(24)
	) u_strap_sync (
		.i_clk(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_d({i_max_current_strap_pin, i_fast_slew_strap, i_boot_strap}),
		.o_q(strap_s)
	);

	// Wait for the synchroniser to fill, then catch once and freeze
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strap_cnt <= 2'h0;
			o_strap_done <= 1'b0;
			platform_max_current <= RST_ZERO;
			fast_slew_rate <= RST_ZERO;
			boot_voltage <= RST_ZERO;
		end else if (!o_strap_done) begin
			if (strap_cnt == STRAP_SETTLE) begin
				o_strap_done <= 1'b1;
				platform_max_current <= strap_s[23:16];
				fast_slew_rate <= strap_s[15:8];
				boot_voltage <= strap_s[7:0];
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Telemetry scaling
	logic [15:0] cur_scaled;
	logic [15:0] vout_scaled;
	logic [23:0] vin_scaled;
	logic [15:0] pout_prod;
	logic [7:0] output_current_reading;
	logic [7:0] output_voltage_reading;
	logic [7:0] temperature_reading;
	logic [7:0] output_power_reading;
	logic [7:0] input_voltage_reading;
	logic [7:0] input_power_reading;

	// Divider is wide but only runs on slow-moving values
	always_comb begin
		if (platform_max_current == RST_ZERO) begin
			cur_scaled = {8'h00, FULL_SCALE};
		end else begin
			cur_scaled = ({8'h00, i_meas.current_a} * {8'h00, FULL_SCALE})
				/ {8'h00, platform_max_current};
		end
		if (i_fine_step) begin
			vout_scaled = {4'h0, i_meas.vout_mv} >> FINE_SHIFT;
		end else begin
			vout_scaled = ({4'h0, i_meas.vout_mv} * COARSE_NUM)
				/ COARSE_DEN;
		end
		vin_scaled = ({8'h00, i_meas.vin_mv} * VIN_PER_V) / MV_PER_V
			+ VIN_OFFSET;
		pout_prod = output_voltage_reading * output_current_reading;
	end

	// Readings refresh every cycle once the straps are caught; scaled ones saturate at full scale
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			output_current_reading <= RST_TELEM;
			output_voltage_reading <= RST_TELEM;
			temperature_reading <= RST_TELEM;
			output_power_reading <= RST_TELEM;
			input_voltage_reading <= RST_TELEM;
			input_power_reading <= RST_ZERO;
		end else if (o_strap_done) begin
			output_current_reading <= (cur_scaled > {8'h00, FULL_SCALE}) ?
				FULL_SCALE : cur_scaled[7:0];
			output_voltage_reading <= (vout_scaled > {8'h00, FULL_SCALE}) ?
				FULL_SCALE : vout_scaled[7:0];
			temperature_reading <= i_meas.temp_valid ?
				i_meas.temp_c : RST_ZERO;
			output_power_reading <= pout_prod[15:8];
			input_voltage_reading <= (vin_scaled > {16'h0000, FULL_SCALE}) ?
				FULL_SCALE : vin_scaled[7:0];
			input_power_reading <= i_meas.pin;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writable registers and the status snapshot
	logic [7:0] current_limit_level;
	logic [7:0] slow_rate_divider_select;
	logic [7:0] status_two_snapshot;
	logic [7:0] status_two_live;
	logic main_wr;

	// Status bits sit at their fixed positions, upper bits zero
	always_comb begin
		status_two_live = 8'h00;
		status_two_live[STAT_CLIM_BIT] = i_status_two[2];
		status_two_live[STAT_FRAME_BIT] = i_status_two[1];
		status_two_live[STAT_PARITY_BIT] = i_status_two[0];
	end

	assign main_wr = access && req_hold.wr && !req_hold.psys;

	// Only these two registers accept writes; others ignore them
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			current_limit_level <= RST_ZERO;
			slow_rate_divider_select <= RST_SR_SEL;
		end else if (main_wr) begin
			if (req_hold.addr == ADDR_CLIM) begin
				current_limit_level <= req_hold.wdata;
			end
			if (req_hold.addr == ADDR_SR_SEL) begin
				slow_rate_divider_select <= req_hold.wdata;
			end
		end
	end

	// A read of the live status register copies it here
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_two_snapshot <= RST_ZERO;
		end else if (access && !req_hold.wr && !req_hold.psys
			&& req_hold.addr == ADDR_STATUS_TWO) begin
			status_two_snapshot <= status_two_live;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slow slew rate from the selector
	logic [7:0] slow_slew_rate;

	// Unknown selector codes fall back to the usual divide by four
	always_comb begin
		unique case (slow_rate_divider_select)
			SEL_DIV2: slow_slew_rate = fast_slew_rate >> 1;
			SEL_DIV4: slow_slew_rate = fast_slew_rate >> 2;
			SEL_DIV8: slow_slew_rate = fast_slew_rate >> 3;
			SEL_DIV16: slow_slew_rate = fast_slew_rate >> 4;
			default: slow_slew_rate = fast_slew_rate >> 2;
		endcase
	end

	assign o_slow_slew_rate = slow_slew_rate;
	assign o_current_limit_level = current_limit_level;

	////////////////////////////////////////////////////////////////////////
	// Voltage target: boot value until a set-voltage command after strap capture
	logic got_set_voltage;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			got_set_voltage <= 1'b0;
			o_target_voltage_code <= RST_ZERO;
		end else if (i_set_voltage_valid && o_strap_done) begin
			got_set_voltage <= 1'b1;
			o_target_voltage_code <= i_set_voltage_code;
		end else if (!got_set_voltage) begin
			o_target_voltage_code <= boot_voltage;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read decode and answer
	vrt_rsp_s rsp_next;
	logic wr_ok;

	// Writes succeed only on the two writable registers
	assign wr_ok = !req_hold.psys && (req_hold.addr == ADDR_CLIM
		|| req_hold.addr == ADDR_SR_SEL);

	always_comb begin
		rsp_next.rdata = 8'h00;
		rsp_next.ok = 1'b1;
		if (req_hold.wr) begin
			rsp_next.ok = wr_ok;
		end else if (req_hold.psys) begin
			unique case (req_hold.addr)
				ADDR_IOUT: rsp_next.rdata = output_current_reading;
				ADDR_PIN: rsp_next.rdata = input_power_reading;
				ADDR_MAX_CURRENT_STRAP_PIN: rsp_next.rdata = platform_max_current;
				default: rsp_next.ok = 1'b0;
			endcase
		end else begin
			unique case (req_hold.addr)
				ADDR_STATUS_TWO: rsp_next.rdata = status_two_live;
				ADDR_IOUT: rsp_next.rdata = output_current_reading;
				ADDR_VOUT: rsp_next.rdata = output_voltage_reading;
				ADDR_TEMP: rsp_next.rdata = temperature_reading;
				ADDR_POUT: rsp_next.rdata = output_power_reading;
				ADDR_VIN: rsp_next.rdata = input_voltage_reading;
				ADDR_SNAP: rsp_next.rdata = status_two_snapshot;
				ADDR_CLIM: rsp_next.rdata = current_limit_level;
				ADDR_MAX_CURRENT_STRAP_PIN: rsp_next.rdata = platform_max_current;
				ADDR_TMAX: rsp_next.rdata = RST_TMAX;
				ADDR_FAST_SLEW_RATE: rsp_next.rdata = fast_slew_rate;
				ADDR_SLOW_SLEW_RATE: rsp_next.rdata = slow_slew_rate;
				ADDR_BOOT: rsp_next.rdata = boot_voltage;
				ADDR_SR_SEL: rsp_next.rdata = slow_rate_divider_select;
				ADDR_DEEP_LAT: rsp_next.rdata = VAL_DEEP_LAT;
				ADDR_LIGHT_LAT: rsp_next.rdata = VAL_LIGHT_LAT;
				default: rsp_next.ok = 1'b0;
			endcase
		end
	end

	// Answer is held, then the ack toggle goes back across
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_seen <= 1'b0;
			ack_tgl <= 1'b0;
			rsp_hold <= '0;
		end else if (access) begin
			req_seen <= req_s;
			rsp_hold <= rsp_next;
			ack_tgl <= ~ack_tgl;
		end
	end

endmodule : vrt_regs

//--- src/vrt_sync.sv
// Purpose: Two-flop level synchroniser of parameter width
// Assumes: Each bit is a level or a slow toggle
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps

module vrt_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta;

	////////////////////////////////////////////////////////////////////////
	// Two stages; the first is seen by nothing but the second
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end

endmodule : vrt_sync

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the telemetry register bank
// Assumes: Host model drives the link side
// Notes: Expected readings are worked out from the driven inputs
`timescale 1ns/1ps

module tb_top;
	import vrt_pkg::*;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid, busy, done, fine, sv_valid, strap_done;
	vrt_req_s req;
	vrt_rsp_s rsp, r;
	vrt_meas_s meas;
	logic [2:0] stat2;
	logic [7:0] iccm, fast, boot, sv_code, limit, slow, target;
	int bad_count = 0;
	int compares = 0;
	// Address, expected data, expected ok
	logic [23:0] tab [17] = '{24'h15ff01, 24'h166401, 24'h176401,
		24'h186301, 24'h1a5601, 24'h1c0001, 24'h1f0001, 24'h218001,
		24'h226401, 24'h244001, 24'h252001, 24'h265a01, 24'h2a0201,
		24'h2b7b01, 24'h2c5501, 24'h300000, 24'h1b0000};
	logic [7:0] sel [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h07};
	int sh [5] = '{1, 2, 3, 4, 2};

	// Odd link edges never meet the even system edges
	always #4 clk_sys = ~clk_sys;
	always #15 clk_link = ~clk_link;

	vrt_regs u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_clk_link(clk_link), .i_link_req_valid(req_valid),
		.i_link_req(req), .o_link_busy(busy), .o_link_done(done),
		.o_link_rsp(rsp), .i_meas(meas), .i_fine_step(fine),
		.i_status_two(stat2), .i_max_current_strap_pin(iccm),
		.i_fast_slew_strap(fast), .i_boot_strap(boot),
		.i_set_voltage_valid(sv_valid), .i_set_voltage_code(sv_code),
		.o_strap_done(strap_done), .o_current_limit_level(limit),
		.o_slow_slew_rate(slow), .o_target_voltage_code(target));
	vrt_host u_host (.i_clk_link(clk_link), .o_req_valid(req_valid),
		.o_req(req), .i_busy(busy), .i_done(done), .i_rsp(rsp));

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic p,
		input logic [7:0] e, input logic ok);
		u_host.access('{a, p, 1'b0, 8'h00}, 0, r);
		chk(r.rdata, e);
		chk({7'h00, r.ok}, {7'h00, ok});
	endtask : rd
	// Writes idle two link cycles first, like a slower host
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic ok);
		u_host.access('{a, 1'b0, 1'b1, d}, 2, r);
		chk({7'h00, r.ok}, {7'h00, ok});
	endtask : wr
	task automatic tally_and_finish;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the roughly 7 us the tests need
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		meas = '{8'h80, 12'h320, 8'h64, 1'b1, 16'h2ee0, 8'h33};
		fine = 1'b1;
		stat2 = 3'h5;
		iccm = 8'h80;
		fast = 8'h40;
		boot = 8'h5a;
		sv_valid = 1'b0;
		sv_code = 8'h00;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk({7'h00, strap_done}, 8'h01);
		chk(target, 8'h5a);
		foreach (tab[i])
			rd(tab[i][23:16], 1'b0, tab[i][15:8], tab[i][0]);
		rd(8'h1b, 1'b1, 8'h33, 1'b1);
		$display("test readings done");
		rd(8'h11, 1'b0, 8'h05, 1'b1);
		rd(8'h1c, 1'b0, 8'h05, 1'b1);
		@(posedge clk_sys);
		stat2 <= 3'h2;
		rd(8'h1c, 1'b0, 8'h05, 1'b1);
		rd(8'h11, 1'b0, 8'h02, 1'b1);
		rd(8'h1c, 1'b0, 8'h02, 1'b1);
		$display("test snapshot done");
		wr(8'h1f, 8'ha5, 1'b1);
		rd(8'h1f, 1'b0, 8'ha5, 1'b1);
		chk(limit, 8'ha5);
		wr(8'h21, 8'h11, 1'b0);
		wr(8'h22, 8'h11, 1'b0);
		wr(8'h2b, 8'h11, 1'b0);
		@(posedge clk_sys);
		iccm <= 8'h22;
		rd(8'h21, 1'b0, 8'h80, 1'b1);
		rd(8'h22, 1'b0, 8'h64, 1'b1);
		rd(8'h2b, 1'b0, 8'h7b, 1'b1);
		$display("test writes done");
		for (int i = 0; i < 5; i++) begin
			wr(8'h2a, sel[i], 1'b1);
			rd(8'h25, 1'b0, 8'h40 >> sh[i], 1'b1);
			chk(slow, 8'h40 >> sh[i]);
		end
		$display("test slew done");
		@(posedge clk_sys);
		fine <= 1'b0;
		meas.temp_valid <= 1'b0;
		rd(8'h16, 1'b0, 8'h33, 1'b1);
		rd(8'h17, 1'b0, 8'h00, 1'b1);
		rd(8'h18, 1'b0, 8'h32, 1'b1);
		@(posedge clk_sys);
		sv_valid <= 1'b1;
		sv_code <= 8'h3c;
		@(posedge clk_sys);
		sv_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(target, 8'h3c);
		$display("test voltage done");
		tally_and_finish();
	end
endmodule : tb_top

//--- tb/vrt_host.sv
// Purpose: Link-side host model issuing single-byte accesses
// Assumes: One access in flight; request held until taken
// Notes: Idle request fields show the inverse of the last ones
`timescale 1ns/1ps

module vrt_host (
	input wire logic i_clk_link,
	output logic o_req_valid,
	output vrt_pkg::vrt_req_s o_req,
	input wire logic i_busy,
	input wire logic i_done,
	input wire vrt_pkg::vrt_rsp_s i_rsp
);
	import vrt_pkg::*;
	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
	end
	////////////////////////////////////////////////////////////////////
	// One access; gap idles first so a slow host is covered too
	task automatic access(input vrt_req_s q, input int gap,
		output vrt_rsp_s r);
		int n;
		n = 0;
		repeat (gap) @(posedge i_clk_link);
		o_req_valid <= 1'b1;
		o_req <= q;
		// Held until an idle edge takes it
		do @(posedge i_clk_link); while (i_busy);
		o_req_valid <= 1'b0;
		o_req <= ~q;
		do begin
			@(posedge i_clk_link);
			n++;
		end while (!i_done && n < 16);
		r = i_rsp;
	endtask : access
endmodule : vrt_host

//--- tb/vrt_regs_props.sv
// Purpose: Port checks on the register bank, link and system sides
// Assumes: Only top ports are seen
// Notes: Bound onto every bank instance
`timescale 1ns/1ps

module vrt_regs_props (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_link,
	input wire logic i_link_req_valid,
	input wire logic o_link_busy,
	input wire logic o_link_done,
	input wire vrt_pkg::vrt_rsp_s o_link_rsp,
	input wire logic i_set_voltage_valid,
	input wire logic [7:0] i_set_voltage_code,
	input wire logic o_strap_done,
	input wire logic [7:0] o_target_voltage_code
);
	import vrt_pkg::*;
	////////////////////////////////////////////////////////////////////
	// A request is taken only at an idle link edge
	sequence s_take;
		i_link_req_valid && !o_link_busy;
	endsequence
	// The answer lands inside the crossing's worst case
	sequence s_answer;
		##[2:14] o_link_done;
	endsequence
	chk_take_busy: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		s_take |=> o_link_busy) else $error("busy missing after request");
	chk_take_answer: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		s_take |-> s_answer) else $error("answer late");
	chk_done_pulse: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_link_done |=> !o_link_done) else $error("done too long");
	chk_done_idle: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_link_done |-> !o_link_busy) else $error("busy with done");
	chk_busy_drop: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		o_link_busy && !o_link_done |=> o_link_busy || o_link_done)
		else $error("busy dropped without done");
	// Answer data may only move together with done
	chk_rsp_hold: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
		!o_link_done |-> $stable(o_link_rsp)) else $error("answer moved");
	////////////////////////////////////////////////////////////////////
	chk_strap_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_strap_done |=> o_strap_done) else $error("strap flag fell");
	chk_target_take: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_set_voltage_valid && o_strap_done |=>
		o_target_voltage_code == $past(i_set_voltage_code))
		else $error("target not taken");
	// Two edges of margin so the boot load itself is not caught
	chk_target_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_strap_done && $past(o_strap_done, 2) && !i_set_voltage_valid
		|=> $stable(o_target_voltage_code)) else $error("target moved");
endmodule : vrt_regs_props

bind vrt_regs vrt_regs_props u_props (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_clk_link(i_clk_link),
	.i_link_req_valid(i_link_req_valid), .o_link_busy(o_link_busy),
	.o_link_done(o_link_done), .o_link_rsp(o_link_rsp),
	.i_set_voltage_valid(i_set_voltage_valid),
	.i_set_voltage_code(i_set_voltage_code), .o_strap_done(o_strap_done),
	.o_target_voltage_code(o_target_voltage_code));
